// ==== design/rfc_pkg.sv ====
/*
  Shared constants, types and helper functions for the ring frame codec:
  register map, status field positions, line symbol codes, CRC generator,
  state encodings and the event record that crosses into the host domain.
  Assumes a 10 MHz host clock and a separate link clock.
*/
package rfc_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned TIMEOUT_US  = 500;
  // Longest wait, so the count rounds down
  localparam int unsigned TIMEOUT_CYC = (CLK_HZ / 1_000_000) * TIMEOUT_US;

  // ----------------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------------
  typedef logic [3:0]  rfc_addr_t;
  typedef logic [15:0] rfc_word_t;
  localparam rfc_addr_t  ADDR_CTRL1     = 4'h1;
  localparam rfc_addr_t  ADDR_LINK_STAT = 4'h3;
  localparam int         CTRL1_CLR_MSG  = 0;
  localparam int         CTRL1_CLR_ERR  = 1;
  localparam int         STAT_W         = 7;
  localparam logic [6:0] STAT_RST       = 7'h00;
  localparam int         ST_TIMEOUT     = 6;
  localparam int         ST_ERROR       = 5;
  localparam int         ST_ADDR        = 4;
  localparam int         ST_COPIED      = 3;
  localparam int         ST_CRC         = 2;
  localparam int         ST_ILL_SEQ     = 1;
  localparam int         ST_ILL_DATA    = 0;
  localparam int         WORD_LAST_BIT  = 15;

  // ----------------------------------------------------------------------
  // Line symbols and CRC
  // ----------------------------------------------------------------------
  localparam logic [4:0]  SYM_IDLE  = 5'h1f;
  localparam logic [4:0]  SYM_J     = 5'h18;
  localparam logic [4:0]  SYM_K     = 5'h11;
  localparam logic [4:0]  SYM_H     = 5'h04;
  localparam logic [4:0]  SYM_R     = 5'h07;
  localparam logic [4:0]  SYM_S     = 5'h19;
  localparam logic [4:0]  SYM_T     = 5'h0d;
  localparam logic [15:0] CRC_POLY  = 16'h8005;
  localparam logic [15:0] CRC_INIT  = 16'h0000;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    TX_IDLE = 6'h01, TX_SOF2 = 6'h02, TX_DAT = 6'h04,
    TX_CRC  = 6'h08, TX_EOT  = 6'h10, TX_STS = 6'h20
  } rfc_txst_e;
  typedef enum logic [5:0] {
    RX_HUNT = 6'h01, RX_SOF2 = 6'h02, RX_HI  = 6'h04,
    RX_LO   = 6'h08, RX_TOKT = 6'h10, RX_STS = 6'h20
  } rfc_rxst_e;
  // Order matches receive status word bits 14..9
  typedef struct packed {
    logic eof_ok;
    logic er;
    logic ar;
    logic dc;
    logic crc_err;
    logic ill_seq;
    logic ill_data;
  } rfc_evt_s;
  typedef struct packed {
    logic       is_data;
    logic [3:0] nib;
  } rfc_dec_s;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Nibble to 5-bit data symbol
  function automatic logic [4:0] sym_enc(logic [3:0] n);
    case (n)
      4'h0: return 5'h1e;
      4'h1: return 5'h09;
      4'h2: return 5'h14;
      4'h3: return 5'h15;
      4'h4: return 5'h0a;
      4'h5: return 5'h0b;
      4'h6: return 5'h0e;
      4'h7: return 5'h0f;
      4'h8: return 5'h12;
      4'h9: return 5'h13;
      4'ha: return 5'h16;
      4'hb: return 5'h17;
      4'hc: return 5'h1a;
      4'hd: return 5'h1b;
      4'he: return 5'h1c;
      default: return 5'h1d;
    endcase
  endfunction

  // Reverse lookup; is_data low for any non-data code
  function automatic rfc_dec_s sym_dec(logic [4:0] s);
    rfc_dec_s d;
    d = '0;
    for (int i = 0; i < 16; i++) begin
      if (sym_enc(4'(i)) == s) begin
        d.is_data = 1'b1;
        d.nib     = 4'(i);
      end
    end
    return d;
  endfunction

  // MSB-first CRC over one byte
  function automatic logic [15:0] crc_byte(logic [15:0] c, logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ d[i]) begin
        r = {r[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

endpackage

// ==== design/rfc_rx_sym.sv ====
/*
  Receive symbol aligner on the link clock: synchronises the line, undoes
  NRZI, hunts for the J symbol and then hands out one 5-bit symbol every
  five link clocks until told to hunt again.
  Assumes the line changes only around the link clock's falling edge.
*/
`timescale 1ns/100ps
module rfc_rx_sym (
  input  wire logic       link_clk,   // Link clock
  input  wire logic       lrst_b,     // Link-domain reset, active low
  input  wire logic       link_rx,    // Serial line in
  input  wire logic       resync,     // Return to hunting for J
  output logic            sym_vld,    // Symbol strobe, one cycle
  output logic [4:0]      sym         // Aligned symbol
);
  import rfc_pkg::*;

  logic [1:0] sync_ff;
  logic       lvl_ff;
  logic [4:0] sh_ff,  nxt_sh;
  logic [2:0] cnt_ff, nxt_cnt;
  logic       lock_ff, nxt_lock;
  logic       vld_ff, nxt_vld;
  logic [4:0] sym_ff, nxt_sym;
  logic       bit_in;

  // ----------------------------------------------------------------------
  // Alignment
  // ----------------------------------------------------------------------
  // A line transition is a one
  always_comb begin
    bit_in   = sync_ff[1] ^ lvl_ff;
    nxt_sh   = {sh_ff[3:0], bit_in};
    nxt_cnt  = cnt_ff;
    nxt_lock = lock_ff;
    nxt_vld  = 1'b0;
    nxt_sym  = sym_ff;
    if (resync) begin
      nxt_lock = 1'b0;
    end else if (!lock_ff) begin
      if (nxt_sh == SYM_J) begin
        nxt_lock = 1'b1;
        nxt_cnt  = 3'h0;
        nxt_vld  = 1'b1;
        nxt_sym  = nxt_sh;
      end
    end else if (cnt_ff == 3'h4) begin
      nxt_cnt = 3'h0;
      nxt_vld = 1'b1;
      nxt_sym = nxt_sh;
    end else begin
      nxt_cnt = cnt_ff + 3'h1;
    end
  end

  // Sampled on the rising link edge; two stages before any use
  always_ff @(posedge link_clk or negedge lrst_b) begin
    if (!lrst_b) begin
      sync_ff <= 2'h0;
      lvl_ff  <= 1'b0;
      sh_ff   <= 5'h00;
      cnt_ff  <= 3'h0;
      lock_ff <= 1'b0;
      vld_ff  <= 1'b0;
      sym_ff  <= 5'h00;
    end else begin
      sync_ff <= {sync_ff[0], link_rx};
      lvl_ff  <= sync_ff[1];
      sh_ff   <= nxt_sh;
      cnt_ff  <= nxt_cnt;
      lock_ff <= nxt_lock;
      vld_ff  <= nxt_vld;
      sym_ff  <= nxt_sym;
    end
  end

  assign sym_vld = vld_ff;
  assign sym     = sym_ff;

endmodule

// ==== design/ring_frame_codec.sv ====
/*
  Ring frame codec: builds token and data frames onto a 4b/5b NRZI line,
  receives, checks and unpacks returning frames into the receive FIFO,
  and keeps the host-readable link status register.
  Assumes dual-clock FIFOs outside, whose link-side ports run on link_clk.
*/
`timescale 1ns/100ps
module ring_frame_codec #(
  parameter int unsigned TMO_CYC = rfc_pkg::TIMEOUT_CYC  // Timeout in clk cycles
) (
  input  wire logic              clk,          // Host clock
  input  wire logic              rst_b,        // Async reset, active low
  input  wire rfc_pkg::rfc_addr_t reg_addr,    // Register address
  input  wire logic              reg_wr,       // Register write strobe
  input  wire logic              reg_rd,       // Register read strobe
  input  wire rfc_pkg::rfc_word_t reg_wdata,   // Write data
  output rfc_pkg::rfc_word_t     reg_rdata,    // Read data, next cycle
  output logic                   msg_pending,  // Receive message pending
  input  wire logic              link_clk,     // Link clock
  input  wire rfc_pkg::rfc_word_t tx_word,     // Transmit FIFO head
  input  wire logic              tx_valid,     // Transmit FIFO not empty
  output logic                   tx_ready,     // Transmit FIFO pop
  input  wire logic              tx_token,     // Request a token, pulse
  output logic                   link_tx,      // Serial line out
  input  wire logic              link_rx,      // Serial line in
  output rfc_pkg::rfc_word_t     rx_word,      // Receive FIFO write data
  output logic                   rx_valid      // Receive FIFO write strobe
);
  import rfc_pkg::*;

  // ----------------------------------------------------------------------
  // Link-domain reset: async assert, synchronous release
  // ----------------------------------------------------------------------
  logic [1:0] lrst_ff;
  logic       lrst_b;
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      lrst_ff <= 2'h0;
    end else begin
      lrst_ff <= {lrst_ff[0], 1'b1};
    end
  end
  assign lrst_b = lrst_ff[1];

  // ----------------------------------------------------------------------
  // Transmit framer and NRZI serialiser
  // ----------------------------------------------------------------------
  rfc_txst_e   tx_st_ff, nxt_tx_st;
  logic [4:0]  tsh_ff,   nxt_tsh;
  logic [2:0]  bcnt_ff,  nxt_bcnt;
  logic        line_ff,  nxt_line;
  logic        tok_ff,   nxt_tok;
  logic        treq_ff,  nxt_treq;
  logic        tnib_ff,  nxt_tnib;
  logic [1:0]  tidx_ff,  nxt_tidx;
  logic [15:0] tcrc_ff,  nxt_tcrc;
  logic        tick;

  // One symbol per five link clocks; next symbol chosen at the tick
  always_comb begin
    tick      = (bcnt_ff == 3'h4);
    nxt_tx_st = tx_st_ff;
    nxt_tsh   = {tsh_ff[3:0], 1'b0};
    nxt_bcnt  = tick ? 3'h0 : bcnt_ff + 3'h1;
    nxt_line  = line_ff ^ tsh_ff[4];
    nxt_tok   = tok_ff;
    nxt_treq  = treq_ff;
    nxt_tnib  = tnib_ff;
    nxt_tidx  = tidx_ff;
    nxt_tcrc  = tcrc_ff;
    tx_ready  = 1'b0;
    if (tick) begin
      case (tx_st_ff)
        TX_IDLE: begin
          nxt_tsh = SYM_IDLE;
          if (treq_ff || tx_valid) begin
            nxt_tsh   = SYM_J;
            nxt_tok   = treq_ff;
            nxt_treq  = 1'b0;
            nxt_tx_st = TX_SOF2;
          end
        end
        TX_SOF2: begin
          nxt_tsh   = tok_ff ? SYM_K : SYM_H;
          nxt_tx_st = tok_ff ? TX_EOT : TX_DAT;
          nxt_tnib  = 1'b0;
          nxt_tcrc  = CRC_INIT;
        end
        TX_DAT: begin
          // Underrun shows as idle inside a frame; the FIFO should hold it all
          if (!tx_valid) begin
            nxt_tsh = SYM_IDLE;
          end else if (!tnib_ff) begin
            nxt_tsh  = sym_enc(tx_word[7:4]);
            nxt_tnib = 1'b1;
          end else begin
            nxt_tsh  = sym_enc(tx_word[3:0]);
            nxt_tnib = 1'b0;
            tx_ready = 1'b1;
            nxt_tcrc = crc_byte(tcrc_ff, tx_word[7:0]);
            if (tx_word[WORD_LAST_BIT]) begin
              nxt_tidx  = 2'h0;
              nxt_tx_st = TX_CRC;
            end
          end
        end
        TX_CRC: begin
          nxt_tsh   = sym_enc(tcrc_ff[4'(4'hc - {tidx_ff, 2'h0}) +: 4]);
          nxt_tidx  = tidx_ff + 2'h1;
          nxt_tx_st = (tidx_ff == 2'h3) ? TX_EOT : TX_CRC;
        end
        TX_EOT: begin
          nxt_tsh   = SYM_T;
          nxt_tidx  = 2'h0;
          nxt_tx_st = TX_STS;
        end
        TX_STS: begin
          nxt_tsh   = SYM_R;
          nxt_tidx  = tidx_ff + 2'h1;
          nxt_tx_st = (tidx_ff == 2'h2) ? TX_IDLE : TX_STS;
        end
        default: begin
          nxt_tsh   = SYM_IDLE;
          nxt_tx_st = TX_IDLE;
        end
      endcase
    end
    // A new request in the take cycle is kept
    if (tx_token) begin
      nxt_treq = 1'b1;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_b) begin
    if (!lrst_b) begin
      tx_st_ff <= TX_IDLE;
      tsh_ff   <= SYM_IDLE;
      bcnt_ff  <= 3'h0;
      line_ff  <= 1'b0;
      tok_ff   <= 1'b0;
      treq_ff  <= 1'b0;
      tnib_ff  <= 1'b0;
      tidx_ff  <= 2'h0;
      tcrc_ff  <= CRC_INIT;
    end else begin
      tx_st_ff <= nxt_tx_st;
      tsh_ff   <= nxt_tsh;
      bcnt_ff  <= nxt_bcnt;
      line_ff  <= nxt_line;
      tok_ff   <= nxt_tok;
      treq_ff  <= nxt_treq;
      tnib_ff  <= nxt_tnib;
      tidx_ff  <= nxt_tidx;
      tcrc_ff  <= nxt_tcrc;
    end
  end
  assign link_tx = line_ff;

  // ----------------------------------------------------------------------
  // Receive deframer
  // ----------------------------------------------------------------------
  logic        sym_vld;
  logic [4:0]  sym;
  logic        resync;
  rfc_rxst_e   rx_st_ff, nxt_rx_st;
  logic [7:0]  hold_ff [3];
  logic [7:0]  nxt_hold [3];
  logic [1:0]  hcnt_ff,  nxt_hcnt;
  logic [3:0]  hnib_ff,  nxt_hnib;
  logic [15:0] rcrc_ff,  nxt_rcrc;
  logic        rtok_ff,  nxt_rtok;
  logic [1:0]  sidx_ff,  nxt_sidx;
  logic [2:0]  sts_ff,   nxt_sts;
  logic        cerr_ff,  nxt_cerr;
  rfc_evt_s    evt_ff,   nxt_evt;
  logic        eom_t_ff, nxt_eom_t;
  logic        seen_t_ff, nxt_seen_t;
  rfc_word_t   rxw_ff,   nxt_rxw;
  logic        rxv_ff,   nxt_rxv;
  rfc_dec_s    dec;
  logic        is_ctl;
  logic        bad;
  logic [7:0]  rbyte;

  rfc_rx_sym u_rx_sym (
    .link_clk (link_clk),
    .lrst_b   (lrst_b),
    .link_rx  (link_rx),
    .resync   (resync),
    .sym_vld  (sym_vld),
    .sym      (sym)
  );

  // Last data byte is kept back until the two CRC bytes, the T and the three status symbols behind it are seen
  always_comb begin
    dec    = sym_dec(sym);
    is_ctl = (sym == SYM_IDLE) || (sym == SYM_J) || (sym == SYM_K) || (sym == SYM_H) ||
             (sym == SYM_R) || (sym == SYM_S) || (sym == SYM_T);
    rbyte  = {hnib_ff, dec.nib};
    bad    = 1'b0;
    resync = 1'b0;
    nxt_rx_st = rx_st_ff;
    nxt_hold  = hold_ff;
    nxt_hcnt  = hcnt_ff;
    nxt_hnib  = hnib_ff;
    nxt_rcrc  = rcrc_ff;
    nxt_rtok  = rtok_ff;
    nxt_sidx  = sidx_ff;
    nxt_sts   = sts_ff;
    nxt_cerr  = cerr_ff;
    nxt_evt   = evt_ff;
    nxt_eom_t = eom_t_ff;
    nxt_seen_t = seen_t_ff;
    nxt_rxw   = rxw_ff;
    nxt_rxv   = 1'b0;
    if (sym_vld) begin
      case (rx_st_ff)
        RX_HUNT: begin
          if (sym == SYM_J) begin
            nxt_rx_st = RX_SOF2;
          end
        end
        RX_SOF2: begin
          if (sym == SYM_K || sym == SYM_H) begin
            nxt_rtok   = (sym == SYM_K);
            nxt_rx_st  = (sym == SYM_K) ? RX_TOKT : RX_HI;
            nxt_seen_t = ~seen_t_ff;
            nxt_hcnt   = 2'h0;
            nxt_rcrc   = CRC_INIT;
          end else begin
            bad = 1'b1;
          end
        end
        RX_TOKT: begin
          bad      = (sym != SYM_T);
          nxt_sidx = 2'h0;
          nxt_rx_st = RX_STS;
        end
        RX_HI: begin
          if (dec.is_data) begin
            nxt_hnib  = dec.nib;
            nxt_rx_st = RX_LO;
          end else if (sym == SYM_T && hcnt_ff == 2'h3) begin
            nxt_cerr  = (rcrc_ff != 16'h0000);
            nxt_sidx  = 2'h0;
            nxt_rx_st = RX_STS;
          end else begin
            bad = 1'b1;
          end
        end
        RX_LO: begin
          if (dec.is_data) begin
            nxt_rcrc = crc_byte(rcrc_ff, rbyte);
            nxt_hold[0] = rbyte;
            nxt_hold[1] = hold_ff[0];
            nxt_hold[2] = hold_ff[1];
            if (hcnt_ff == 2'h3) begin
              nxt_rxw = {8'h00, hold_ff[2]};
              nxt_rxv = 1'b1;
            end else begin
              nxt_hcnt = hcnt_ff + 2'h1;
            end
            nxt_rx_st = RX_HI;
          end else begin
            bad = 1'b1;
          end
        end
        RX_STS: begin
          if (sym == SYM_R || sym == SYM_S) begin
            nxt_sts[2'h2 - sidx_ff] = (sym == SYM_S);
            nxt_sidx = sidx_ff + 2'h1;
            if (sidx_ff == 2'h2) begin
              resync    = 1'b1;
              nxt_rx_st = RX_HUNT;
              if (!rtok_ff) begin
                nxt_evt   = {1'b1, nxt_sts, cerr_ff, 2'b00};
                nxt_rxw   = {1'b1, nxt_evt[5:0], 1'b0, hold_ff[2]};
                nxt_rxv   = 1'b1;
                nxt_eom_t = ~eom_t_ff;
              end
            end
          end else begin
            bad = 1'b1;
          end
        end
        default: begin
          nxt_rx_st = RX_HUNT;
        end
      endcase
      // Truncate the message and go back to hunting
      if (bad) begin
        nxt_evt   = '0;
        nxt_evt.ill_data = !dec.is_data && !is_ctl;
        nxt_evt.ill_seq  = dec.is_data || is_ctl;
        nxt_rxw   = {1'b1, nxt_evt[5:0], 1'b0, 8'h00};
        nxt_rxv   = 1'b1;
        nxt_eom_t = ~eom_t_ff;
        nxt_rx_st = RX_HUNT;
        resync    = 1'b1;
      end
    end
  end

  always_ff @(posedge link_clk or negedge lrst_b) begin
    if (!lrst_b) begin
      rx_st_ff  <= RX_HUNT;
      hold_ff   <= '{default: 8'h00};
      hcnt_ff   <= 2'h0;
      hnib_ff   <= 4'h0;
      rcrc_ff   <= CRC_INIT;
      rtok_ff   <= 1'b0;
      sidx_ff   <= 2'h0;
      sts_ff    <= 3'h0;
      cerr_ff   <= 1'b0;
      evt_ff    <= '0;
      eom_t_ff  <= 1'b0;
      seen_t_ff <= 1'b0;
      rxw_ff    <= 16'h0000;
      rxv_ff    <= 1'b0;
    end else begin
      rx_st_ff  <= nxt_rx_st;
      hold_ff   <= nxt_hold;
      hcnt_ff   <= nxt_hcnt;
      hnib_ff   <= nxt_hnib;
      rcrc_ff   <= nxt_rcrc;
      rtok_ff   <= nxt_rtok;
      sidx_ff   <= nxt_sidx;
      sts_ff    <= nxt_sts;
      cerr_ff   <= nxt_cerr;
      evt_ff    <= nxt_evt;
      eom_t_ff  <= nxt_eom_t;
      seen_t_ff <= nxt_seen_t;
      rxw_ff    <= nxt_rxw;
      rxv_ff    <= nxt_rxv;
    end
  end
  assign rx_word  = rxw_ff;
  assign rx_valid = rxv_ff;

  // ----------------------------------------------------------------------
  // Host domain: event crossing, timeout and link status register
  // ----------------------------------------------------------------------
  localparam int TW = $clog2(TMO_CYC + 1);
  logic [2:0]       eom_s_ff, seen_s_ff;
  logic [TW-1:0]    tmo_ff,   nxt_tmo;
  logic [STAT_W-1:0] stat_ff, nxt_stat;
  logic             pend_ff,  nxt_pend;
  rfc_word_t        rd_ff,    nxt_rd;
  logic             eom_ev, seen_ev, clr_msg, clr_err;

  // Event record is held stable by the link side for a whole frame
  always_comb begin
    eom_ev  = eom_s_ff[2] ^ eom_s_ff[1];
    seen_ev = seen_s_ff[2] ^ seen_s_ff[1];
    clr_msg = reg_wr && (reg_addr == ADDR_CTRL1) && reg_wdata[CTRL1_CLR_MSG];
    clr_err = reg_wr && (reg_addr == ADDR_CTRL1) && reg_wdata[CTRL1_CLR_ERR];
    nxt_stat = stat_ff;
    nxt_pend = pend_ff;
    // Clearing restarts the wait so the flag means a fresh silence
    nxt_tmo = (seen_ev || clr_err) ? '0 :
              (tmo_ff == TW'(TMO_CYC)) ? tmo_ff : tmo_ff + 1'b1;
    if (clr_err) begin
      nxt_stat[ST_TIMEOUT]  = 1'b0;
      nxt_stat[ST_CRC]      = 1'b0;
      nxt_stat[ST_ILL_SEQ]  = 1'b0;
      nxt_stat[ST_ILL_DATA] = 1'b0;
    end
    if (clr_msg) begin
      nxt_pend = 1'b0;
      nxt_stat[ST_ERROR:ST_COPIED] = 3'h0;
    end
    // Sets after clears: an event in the clear cycle survives
    if (tmo_ff == TW'(TMO_CYC - 1) && !seen_ev) begin
      nxt_stat[ST_TIMEOUT] = 1'b1;
    end
    if (eom_ev) begin
      nxt_pend = 1'b1;
      if (evt_ff.eof_ok) begin
        nxt_stat[ST_ERROR:ST_COPIED] = {evt_ff.er, evt_ff.ar, evt_ff.dc};
      end
      nxt_stat[ST_CRC]      = nxt_stat[ST_CRC] | evt_ff.crc_err;
      nxt_stat[ST_ILL_SEQ]  = nxt_stat[ST_ILL_SEQ] | evt_ff.ill_seq;
      nxt_stat[ST_ILL_DATA] = nxt_stat[ST_ILL_DATA] | evt_ff.ill_data;
    end
    // Only CTRL1 writes touch the status register; writes to the status address are ignored
    nxt_rd = rd_ff;
    if (reg_rd) begin
      nxt_rd = (reg_addr == ADDR_LINK_STAT) ? {9'h000, stat_ff} : 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      eom_s_ff  <= 3'h0;
      seen_s_ff <= 3'h0;
      tmo_ff    <= '0;
      stat_ff   <= STAT_RST;
      pend_ff   <= 1'b0;
      rd_ff     <= 16'h0000;
    end else begin
      eom_s_ff  <= {eom_s_ff[1:0], eom_t_ff};
      seen_s_ff <= {seen_s_ff[1:0], seen_t_ff};
      tmo_ff    <= nxt_tmo;
      stat_ff   <= nxt_stat;
      pend_ff   <= nxt_pend;
      rd_ff     <= nxt_rd;
    end
  end
  assign reg_rdata   = rd_ff;
  assign msg_pending = pend_ff;

endmodule

// ==== testbench/rfc_properties.sv ====
/* Port checker for the ring frame codec.
   Bound to each codec instance; sees its ports only. */
`timescale 1ns/100ps
module rfc_properties #(
  parameter int unsigned TMO_CYC = 50  // Timeout cycles
) (
  input wire logic               clk,         // Host clock
  input wire logic               rst_b,       // Reset, low
  input wire rfc_pkg::rfc_addr_t reg_addr,    // Address
  input wire logic               reg_wr,      // Write
  input wire logic               reg_rd,      // Read
  input wire rfc_pkg::rfc_word_t reg_wdata,   // Write data
  input wire rfc_pkg::rfc_word_t reg_rdata,   // Read data
  input wire logic               msg_pending, // Pending
  input wire logic               link_clk,    // Link clock
  input wire logic               tx_valid,    // Head valid
  input wire logic               tx_ready,    // Pop
  input wire logic               rx_valid,    // Write strobe
  input wire rfc_pkg::rfc_word_t rx_word      // Write data
);
  // Host side
  AST_RD_TOP: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd |=> reg_rdata[15:7] == 9'h000) else $error("status high bits set");
  AST_RD_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  AST_RD_OTHER: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr != 4'h3 |=> reg_rdata == 16'h0000) else $error("unmapped read");
  AST_CLR_MSG: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == 4'h1 && reg_wdata[0] |=> !msg_pending) else $error("pending kept");
  AST_CLR_ERR: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == 4'h1 && reg_wdata[1] ##1 reg_rd && reg_addr == 4'h3
    |=> reg_rdata[2:0] == 3'h0) else $error("error flags kept");
  // Link side; a byte spans ten link clocks
  AST_RX_PULSE: assert property (@(posedge link_clk) disable iff (!rst_b)
    rx_valid |=> !rx_valid) else $error("write strobe too long");
  AST_TX_POP: assert property (@(posedge link_clk) disable iff (!rst_b)
    tx_ready |-> tx_valid) else $error("pop from empty fifo");
  AST_TX_GAP: assert property (@(posedge link_clk) disable iff (!rst_b)
    tx_ready |=> !tx_ready [*8]) else $error("pops too close");
  cover property (@(posedge link_clk) rx_valid && rx_word[15]);
  cover property (@(posedge link_clk) tx_ready);
  cover property (@(posedge clk) reg_rd && reg_addr == 4'h3);
endmodule

bind ring_frame_codec rfc_properties #(.TMO_CYC(TMO_CYC)) u_props (.clk(clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .msg_pending(msg_pending), .link_clk(link_clk), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_word(rx_word));

// ==== testbench/rfc_node.sv ====
/* Remote ring node: sends frames to the codec, decodes its line.
   Link clock comes from the bench. */
`timescale 1ns/100ps
module rfc_node (
  input wire logic link_clk, // Link clock
  input wire logic link_tx,  // Codec line out
  output logic     link_rx   // Codec line in
);
  bit          q[$];
  logic        prev = 1'b0;
  logic [29:0] sh = '0;
  logic [4:0]  enc[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                           5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  initial link_rx = 1'b0;
  // Idle symbols when nothing queued; change off the sampling edge
  always @(negedge link_clk) link_rx <= link_rx ^ (q.size() ? q.pop_front() : 1'b1);
  // Undo line coding of the codec output
  always @(posedge link_clk) begin
    sh   <= {sh[28:0], link_tx ^ prev};
    prev <= link_tx;
  end
  task sym(input logic [4:0] s);
    for (int i = 4; i >= 0; i--) q.push_back(s[i]);
  endtask
  task byt(input logic [7:0] b);
    sym(enc[b[7:4]]);
    sym(enc[b[3:0]]);
  endtask
  function automatic logic [15:0] crc(logic [15:0] c, logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h8005 : 16'h0);
    return c;
  endfunction
  // Mode 1 spoils the check word, mode 2 stops after an unknown code, mode 3 after T
  task frame(input logic [7:0] d[$], input logic [2:0] st, input int md);
    logic [15:0] c;
    c = '0;
    sym(5'h18);
    sym(md == 2 ? 5'h00 : md == 3 ? 5'h0d : 5'h04);
    if (md >= 2) return;
    foreach (d[i]) begin
      byt(d[i]);
      c = crc(c, d[i]);
    end
    if (md == 1) c = ~c;
    byt(c[15:8]);
    byt(c[7:0]);
    sym(5'h0d);
    for (int i = 2; i >= 0; i--) sym(st[i] ? 5'h19 : 5'h07);
  endtask
endmodule

// ==== testbench/ring_frame_codec_tb.sv ====
/* Self-checking bench for the ring frame codec.
   Drives registers and link inputs at falling edges. */
`timescale 1ns/100ps
module ring_frame_codec_tb;
  import rfc_pkg::*;
  logic clk = 0, rst_b = 0, link_clk = 0, reg_wr = 0, reg_rd = 0, tx_valid = 0, tx_token = 0;
  logic msg_pending, tx_ready, link_tx, link_rx, rx_valid;
  rfc_addr_t reg_addr = '0;
  rfc_word_t reg_wdata = '0, tx_word = '0, reg_rdata, rx_word, last;
  int fail_count = 0, compares = 0, cycles = 0;
  logic [15:0] lw[4] = '{16'hb001, 16'hc801, 16'h8200, 16'h8400};
  logic [5:0] sx[4] = '{6'h18, 6'h24, 6'h01, 6'h02};
  logic [2:0] st[4] = '{3'b011, 3'b100, 3'b000, 3'b000};
  always #50 clk = ~clk;
  always #40 link_clk = ~link_clk;
  ring_frame_codec #(.TMO_CYC(50)) u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .msg_pending(msg_pending), .link_clk(link_clk), .tx_word(tx_word), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_token(tx_token), .link_tx(link_tx), .link_rx(link_rx),
    .rx_word(rx_word), .rx_valid(rx_valid));
  rfc_node u_node (.link_clk(link_clk), .link_tx(link_tx), .link_rx(link_rx));
  always @(posedge link_clk) if (rx_valid) last <= rx_word;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end
  task chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      fail_count++;
    end
  endtask
  // Both bus tasks start and end at a falling edge
  task wr(input rfc_addr_t a, input rfc_word_t d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clk) reg_wr = 0;
  endtask
  task rd(input rfc_addr_t a, input rfc_word_t m, e);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk) reg_rd = 0;
    chk(reg_rdata & m, e);
  endtask
  task lwait(input logic [29:0] m, e);
    for (int n = 0; n < 300 && (u_node.sh & m) !== e; n++) @(negedge link_clk);
    chk({2'b00, u_node.sh & m}, {2'b00, e});
  endtask
  task close_out;
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk) rst_b = 1;
    repeat (60) @(negedge clk);
    rd(4'h9, 16'hffff, 16'h0000);
    wr(ADDR_LINK_STAT, 16'hffff);
    rd(ADDR_LINK_STAT, 16'hffff, 16'h0040);
    wr(ADDR_CTRL1, 16'h0002);
    rd(ADDR_LINK_STAT, 16'hffff, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      last = '0;
      u_node.frame('{8'h01, 8'h02, 8'h02, 8'h05, 8'h01}, st[i], i);
      for (int n = 0; n < 600 && !(last[15] === 1'b1 && u_node.q.size() == 0); n++) @(negedge clk);
      repeat (6) @(negedge clk);
      chk(last, lw[i]);
      rd(ADDR_LINK_STAT, 16'h003f, sx[i]);
      wr(ADDR_CTRL1, 16'h0003);
      rd(ADDR_LINK_STAT, 16'h003f, 16'h0000);
    end
    chk(msg_pending, 0);
    @(negedge link_clk) tx_token = 1;
    @(negedge link_clk) tx_token = 0;
    lwait('1, {SYM_J, SYM_K, SYM_T, SYM_R, SYM_R, SYM_R});
    tx_word = 16'h80a5;
    tx_valid = 1;
    for (int n = 0; n < 300 && tx_ready !== 1'b1; n++) @(negedge link_clk);
    chk(tx_ready, 1);
    @(negedge link_clk) tx_valid = 0;
    lwait(30'hfffff, {10'h0, SYM_J, SYM_H, 5'h16, 5'h0b});
    close_out();
  end
endmodule
